// *** src/aais_pkg.sv ***
// Package with the register map, instruction fields, opcodes and states of the ALU block.
package aais_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [7:0] ADDR_INSTR    = 8'h00;
  localparam logic [7:0] ADDR_ACC      = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_PC       = 8'h0C;
  localparam logic [7:0] ADDR_RETURN   = 8'h10;
  localparam logic [7:0] ADDR_REGS     = 8'h40;
  localparam logic [7:0] ADDR_REGS_END = 8'h7C;

  // Instruction word fields.
  localparam int unsigned OP_LSB   = 24;
  localparam int unsigned OP_MSB   = 28;
  localparam int unsigned BIT_LSB  = 16;
  localparam int unsigned BIT_MSB  = 18;
  localparam int unsigned TGT_MSB  = 12;
  localparam int unsigned OPER_MSB = 7;
  localparam int unsigned RIDX_MSB = 3;

  // Status register bit positions.
  localparam int unsigned SB_CARRY   = 0;
  localparam int unsigned SB_DIGIT   = 1;
  localparam int unsigned SB_ZERO    = 2;
  localparam int unsigned SB_OVER    = 3;
  localparam int unsigned SB_BUSY    = 8;
  localparam int unsigned SB_DISCARD = 9;

  // Reset values.
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST  = 13'h0000;

  // Opcodes carried in the instruction word.
  typedef enum logic [4:0] {
    OP_ADD_REG_TO_ACC       = 5'h00,
    OP_ADD_ACC_TO_REG       = 5'h01,
    OP_ADD_CARRY_TO_ACC     = 5'h02,
    OP_ADD_CARRY_TO_REG     = 5'h03,
    OP_ADD_LITERAL_TO_ACC   = 5'h04,
    OP_REVERSE_SUB_TO_ACC   = 5'h05,
    OP_REVERSE_SUB_TO_REG   = 5'h06,
    OP_REV_SUB_BORROW_ACC   = 5'h07,
    OP_REV_SUB_BORROW_REG   = 5'h08,
    OP_AND_REG_TO_ACC       = 5'h09,
    OP_AND_ACC_TO_REG       = 5'h0A,
    OP_AND_LITERAL_TO_ACC   = 5'h0B,
    OP_CALL                 = 5'h0C,
    OP_UNCONDITIONAL_JUMP   = 5'h0D,
    OP_ZERO_ACCUMULATOR     = 5'h0E,
    OP_ZERO_REGISTER        = 5'h0F,
    OP_ZERO_SINGLE_BIT      = 5'h10,
    OP_DECREMENT_TO_ACC     = 5'h11,
    OP_DECREMENT_IN_PLACE   = 5'h12,
    OP_INCREMENT_TO_ACC     = 5'h13,
    OP_INCREMENT_IN_PLACE   = 5'h14,
    OP_MOVE_REG_TO_ACC      = 5'h15,
    OP_MOVE_ACC_TO_REG      = 5'h16,
    OP_LOAD_LITERAL         = 5'h17
  } aais_op_type;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_FLUSH = 3'b100
  } aais_state_type;

endpackage : aais_pkg

// *** src/aais_add8.sv ***
// Eight-bit adder with carry out of bit 7, carry out of bit 3 and signed overflow.
`timescale 1ns/1ns
`default_nettype none
module aais_add8 (
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_b,
  input  wire logic       i_cin,
  output logic      [7:0] o_sum,
  output logic            o_c7,
  output logic            o_c3,
  output logic            o_ovf
);

  logic [4:0] lo_sum;
  logic [4:0] hi_sum;

  // Two nibble adds expose the carry between bit 3 and bit 4.
  assign lo_sum = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
  assign hi_sum = {1'b0, i_a[7:4]} + {1'b0, i_b[7:4]} + {4'h0, lo_sum[4]};
  assign o_sum  = {hi_sum[3:0], lo_sum[3:0]};
  assign o_c7   = hi_sum[4];
  assign o_c3   = lo_sum[4];
  // Overflow when both operands share a sign that the sum does not.
  assign o_ovf  = (i_a[7] == i_b[7]) && (o_sum[7] != i_a[7]);

endmodule : aais_add8
`default_nettype wire

// *** src/aais_core.sv ***
// Accumulator ALU executing an instruction subset, with an APB register interface.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module aais_core
  import aais_pkg::*;
(
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR
);

  // Whole state of the block.
  typedef struct packed {
    aais_state_type  state;
    logic [7:0]      acc;
    logic [12:0]     pc;
    logic [12:0]     ret;
    logic            carry;
    logic            digit;
    logic            zero;
    logic            over;
    logic            discard;
    logic [31:0]     instr;
    logic [31:0]     rdata;
    logic [15:0][7:0] regs;
  } aais_regs_type;

  localparam aais_regs_type REGS_RST = '{state: ST_IDLE, acc: ACC_RST, pc: PC_RST, default: '0};

  aais_regs_type q_r;
  aais_regs_type q_nxt;

  logic        busy, exec, mapped, is_reg_addr, wr_fire;
  logic [3:0]  ridx, pidx;
  logic [7:0]  rval, lit, add_b, add_sum;
  logic [2:0]  bsel;
  logic [12:0] target;
  aais_op_type op;
  logic        add_cin, add_c7, add_c3, add_ovf, is_arith;
  logic [31:0] rd_val;

  // Instruction field extraction and operand fetch.
  assign busy   = (q_r.state != ST_IDLE);
  assign exec   = (q_r.state == ST_EXEC);
  assign op     = aais_op_type'(q_r.instr[OP_MSB:OP_LSB]);
  assign ridx   = q_r.instr[RIDX_MSB:0];
  assign lit    = q_r.instr[OPER_MSB:0];
  assign bsel   = q_r.instr[BIT_MSB:BIT_LSB];
  assign target = q_r.instr[TGT_MSB:0];
  assign rval   = q_r.regs[ridx];
  assign pidx   = I_PADDR[5:2];

  // APB decode; writes stall while an instruction is in flight.
  assign is_reg_addr = (I_PADDR >= ADDR_REGS) && (I_PADDR <= ADDR_REGS_END);
  assign mapped      = (I_PADDR[1:0] == 2'h0) &&
                       (is_reg_addr || I_PADDR == ADDR_INSTR || I_PADDR == ADDR_ACC ||
                        I_PADDR == ADDR_STATUS || I_PADDR == ADDR_PC ||
                        I_PADDR == ADDR_RETURN);
  assign O_PREADY    = ~(I_PWRITE && busy);
  assign O_PSLVERR   = I_PSEL && I_PENABLE && O_PREADY && !mapped;
  assign wr_fire     = I_PSEL && I_PENABLE && I_PWRITE && !busy && mapped;
  assign O_PRDATA    = q_r.rdata;

  // Adder operand selection for add, carry-add and reverse-subtract forms.
  always_comb begin
    add_b    = rval;
    add_cin  = 1'b0;
    is_arith = 1'b1;
    unique case (op)
      OP_ADD_REG_TO_ACC, OP_ADD_ACC_TO_REG: add_cin = 1'b0;
      OP_ADD_CARRY_TO_ACC, OP_ADD_CARRY_TO_REG: add_cin = q_r.carry;
      OP_ADD_LITERAL_TO_ACC: add_b = lit;
      OP_REVERSE_SUB_TO_ACC, OP_REVERSE_SUB_TO_REG: begin
        add_b   = ~rval;
        add_cin = 1'b1;
      end
      OP_REV_SUB_BORROW_ACC, OP_REV_SUB_BORROW_REG: begin
        add_b   = ~rval;
        add_cin = ~q_r.carry;
      end
      default: is_arith = 1'b0;
    endcase
  end

  aais_add8 u_add (
    .i_a   (q_r.acc),
    .i_b   (add_b),
    .i_cin (add_cin),
    .o_sum (add_sum),
    .o_c7  (add_c7),
    .o_c3  (add_c3),
    .o_ovf (add_ovf)
  );

  // Read data mux for the register map.
  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_reg_addr) begin
      rd_val[7:0] = q_r.regs[pidx];
    end else begin
      unique case (I_PADDR)
        ADDR_INSTR:  rd_val = q_r.instr;
        ADDR_ACC:    rd_val[7:0] = q_r.acc;
        ADDR_PC:     rd_val[12:0] = q_r.pc;
        ADDR_RETURN: rd_val[12:0] = q_r.ret;
        ADDR_STATUS: begin
          rd_val[SB_CARRY]   = q_r.carry;
          rd_val[SB_DIGIT]   = q_r.digit;
          rd_val[SB_ZERO]    = q_r.zero;
          rd_val[SB_OVER]    = q_r.over;
          rd_val[SB_BUSY]    = busy;
          rd_val[SB_DISCARD] = q_r.discard;
        end
        default:     rd_val = 32'h0000_0000;
      endcase
    end
  end

  // Next-state logic: bus writes, sequencing and instruction execution.
  always_comb begin
    q_nxt = q_r;
    if (I_PSEL && !I_PENABLE) q_nxt.rdata = rd_val;
    if (wr_fire) begin
      if (is_reg_addr) begin
        q_nxt.regs[pidx] = I_PWDATA[7:0];
      end else begin
        unique case (I_PADDR)
          ADDR_INSTR: begin
            q_nxt.instr   = I_PWDATA;
            q_nxt.discard = 1'b0;
            q_nxt.state   = ST_EXEC;
          end
          ADDR_ACC:    q_nxt.acc = I_PWDATA[7:0];
          ADDR_PC:     q_nxt.pc = I_PWDATA[12:0];
          ADDR_STATUS: begin
            q_nxt.carry = I_PWDATA[SB_CARRY];
            q_nxt.digit = I_PWDATA[SB_DIGIT];
            q_nxt.zero  = I_PWDATA[SB_ZERO];
            q_nxt.over  = I_PWDATA[SB_OVER];
          end
          default:     q_nxt.ret = q_r.ret;
        endcase
      end
    end
    unique case (q_r.state)
      ST_IDLE: q_nxt.discard = q_nxt.discard;
      ST_EXEC: begin
        q_nxt.state = ST_IDLE;
        q_nxt.pc    = 13'(q_r.pc + 13'h0001);
        if (is_arith) begin
          q_nxt.carry = add_c7;
          q_nxt.digit = add_c3;
          q_nxt.over  = add_ovf;
          q_nxt.zero  = (add_sum == 8'h00);
        end
        unique case (op)
          OP_ADD_REG_TO_ACC, OP_ADD_CARRY_TO_ACC, OP_REVERSE_SUB_TO_ACC,
          OP_REV_SUB_BORROW_ACC: q_nxt.acc = add_sum;
          OP_ADD_ACC_TO_REG, OP_ADD_CARRY_TO_REG, OP_REVERSE_SUB_TO_REG,
          OP_REV_SUB_BORROW_REG: q_nxt.regs[ridx] = add_sum;
          OP_ADD_LITERAL_TO_ACC: q_nxt.acc = add_sum;
          OP_AND_REG_TO_ACC: begin
            q_nxt.acc  = q_r.acc & rval;
            q_nxt.zero = ((q_r.acc & rval) == 8'h00);
          end
          OP_AND_ACC_TO_REG: begin
            q_nxt.regs[ridx] = q_r.acc & rval;
            q_nxt.zero       = ((q_r.acc & rval) == 8'h00);
          end
          OP_AND_LITERAL_TO_ACC: begin
            q_nxt.acc  = q_r.acc & lit;
            q_nxt.zero = ((q_r.acc & lit) == 8'h00);
          end
          OP_CALL: begin
            q_nxt.ret   = 13'(q_r.pc + 13'h0001);
            q_nxt.pc    = target;
            q_nxt.state = ST_FLUSH;
          end
          OP_UNCONDITIONAL_JUMP: begin
            q_nxt.pc    = target;
            q_nxt.state = ST_FLUSH;
          end
          OP_ZERO_ACCUMULATOR: begin
            q_nxt.acc  = 8'h00;
            q_nxt.zero = 1'b1;
          end
          OP_ZERO_REGISTER: begin
            q_nxt.regs[ridx] = 8'h00;
            q_nxt.zero       = 1'b1;
          end
          OP_ZERO_SINGLE_BIT: q_nxt.regs[ridx][bsel] = 1'b0;
          OP_DECREMENT_TO_ACC: begin
            q_nxt.acc  = 8'(rval - 8'h01);
            q_nxt.zero = (rval == 8'h01);
          end
          OP_DECREMENT_IN_PLACE: begin
            q_nxt.regs[ridx] = 8'(rval - 8'h01);
            q_nxt.zero       = (rval == 8'h01);
          end
          OP_INCREMENT_TO_ACC: begin
            q_nxt.acc  = 8'(rval + 8'h01);
            q_nxt.zero = (rval == 8'hFF);
          end
          OP_INCREMENT_IN_PLACE: begin
            q_nxt.regs[ridx] = 8'(rval + 8'h01);
            q_nxt.zero       = (rval == 8'hFF);
          end
          OP_MOVE_REG_TO_ACC: begin
            q_nxt.acc  = rval;
            q_nxt.zero = (rval == 8'h00);
          end
          OP_MOVE_ACC_TO_REG: q_nxt.regs[ridx] = q_r.acc;
          OP_LOAD_LITERAL: q_nxt.acc = lit;
          default: q_nxt.acc = q_r.acc;
        endcase
      end
      ST_FLUSH: begin
        q_nxt.discard = 1'b1;
        q_nxt.state   = ST_IDLE;
      end
      default: q_nxt.state = ST_IDLE;
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      q_r <= REGS_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Checks of the executed results.
  AST_ADD_ACC: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    exec && op == OP_ADD_REG_TO_ACC |=> q_r.acc == 8'($past(q_r.acc) + $past(rval))
      && q_r.state == ST_IDLE)
    else $error("Add to accumulator result or timing wrong");

  AST_ADDC_REG: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    exec && op == OP_ADD_CARRY_TO_REG |=>
      q_r.regs[$past(ridx)] == 8'($past(q_r.acc) + $past(rval) + {7'h00, $past(q_r.carry)}))
    else $error("Add with carry to register wrong");

  AST_ADD_LIT: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    exec && op == OP_ADD_LITERAL_TO_ACC |=> q_r.acc == 8'($past(q_r.acc) + $past(lit)))
    else $error("Add literal wrong");

  AST_ARITH_FLAGS: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    exec && is_arith |=> q_r.carry == $past(add_c7) && q_r.digit == $past(add_c3)
      && q_r.zero == ($past(add_sum) == 8'h00) && q_r.over == $past(add_ovf))
    else $error("Arithmetic flags not updated");

  AST_RSUB: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    exec && op == OP_REVERSE_SUB_TO_ACC |=> q_r.acc == 8'($past(q_r.acc) - $past(rval)))
    else $error("Reverse subtract wrong");

  AST_RSUB_BORROW: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    exec && op == OP_REV_SUB_BORROW_ACC |=>
      q_r.acc == 8'($past(q_r.acc) - $past(rval) - {7'h00, $past(q_r.carry)}))
    else $error("Reverse subtract with borrow wrong");

  AST_AND_FLAGS: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    exec && (op == OP_AND_REG_TO_ACC || op == OP_AND_ACC_TO_REG) |=>
      $stable(q_r.carry) && $stable(q_r.digit) && $stable(q_r.over))
    else $error("AND changed a flag other than zero");

  AST_CALL: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    exec && op == OP_CALL |=> q_r.pc == $past(target) && q_r.ret == 13'($past(q_r.pc) + 13'h0001)
      && q_r.state == ST_FLUSH ##1 q_r.state == ST_IDLE)
    else $error("Call target, return or cycle count wrong");

  AST_JUMP: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    exec && op == OP_UNCONDITIONAL_JUMP |=> $stable(q_r.carry) && $stable(q_r.zero)
      && q_r.pc == $past(target) ##1 q_r.state == ST_IDLE && q_r.discard)
    else $error("Jump wrong");

  AST_INC_ZERO: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    exec && op == OP_INCREMENT_TO_ACC |=> q_r.acc == 8'($past(rval) + 8'h01)
      && q_r.zero == (q_r.acc == 8'h00) && $stable(q_r.carry))
    else $error("Increment wrong");

  AST_FLUSH: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    q_r.state == ST_FLUSH |=> $stable(q_r.pc) && $stable(q_r.acc) && q_r.discard)
    else $error("Discard cycle altered state");

endmodule : aais_core
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking testbench that runs every instruction of the ALU block over APB.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import aais_pkg::*;

  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rdata;
  logic        rerr;
  int          rwaits;
  int          mismatches;
  int          check_count;
  logic [4:0]  op;
  logic [12:0] tgt;
  logic [12:0] exp_ret;
  logic [31:0] word;
  logic [7:0]  raddr;
  logic [7:0]  ea;
  logic [7:0]  er;
  logic [3:0]  ef;
  logic        xfer;
  // Operand sets: accumulator, register, flags before, literal byte and bit select.
  logic [7:0]  va [4] = '{8'h77, 8'h80, 8'hFF, 8'h00};
  logic [7:0]  vr [4] = '{8'h09, 8'h77, 8'h01, 8'hFF};
  logic [3:0]  vf [4] = '{4'hA, 4'h5, 4'hF, 4'h6};
  logic [7:0]  vl [4] = '{8'h23, 8'h0F, 8'h01, 8'hE7};
  logic [2:0]  vb [4] = '{3'h3, 3'h4, 3'h0, 3'h7};

  aais_core dut (
    .I_REF_CLK (clk),
    .I_RSTN    (rst_n),
    .I_PSEL    (psel),
    .I_PENABLE (penable),
    .I_PWRITE  (pwrite),
    .I_PADDR   (paddr),
    .I_PWDATA  (pwdata),
    .O_PRDATA  (prdata),
    .O_PREADY  (pready),
    .O_PSLVERR (pslverr)
  );

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One APB transfer; chain skips the idle edge, keep holds psel for a following setup.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input bit chain, input bit keep);
    int n;
    n = 0;
    if (!chain) @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) chk("pready", {31'h0, pready}, 32'h1);
    rdata  = prdata;
    rerr   = pslverr;
    rwaits = n - 1;
    penable <= 1'b0;
    if (!keep) psel <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0, 1'b0);
  endtask : wr

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 1'b0, 1'b0);
    chk(name, rdata, e);
  endtask : rd

  // Reference behaviour of one instruction; flags are {overflow, zero, digit carry, carry}.
  task automatic model(input logic [4:0] o, input logic [7:0] a, input logic [7:0] r,
                       input logic [7:0] lit, input logic [2:0] b, input logic [3:0] f,
                       output logic [7:0] oa, output logic [7:0] orr, output logic [3:0] of);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] y;
    logic       ci;
    logic       ar;
    oa  = a;
    orr = r;
    of  = f;
    ar  = 1'b0;
    y   = r;
    ci  = 1'b0;
    case (o)
      5'h00, 5'h01: ar = 1'b1;
      5'h02, 5'h03: begin
        ar = 1'b1;
        ci = f[0];
      end
      5'h04: begin
        ar = 1'b1;
        y  = lit;
      end
      5'h05, 5'h06: begin
        ar = 1'b1;
        y  = ~r;
        ci = 1'b1;
      end
      5'h07, 5'h08: begin
        ar = 1'b1;
        y  = ~r;
        ci = ~f[0];
      end
      default: ar = 1'b0;
    endcase
    s = {1'b0, a} + {1'b0, y} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    if (ar) of = {(a[7] == y[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
    case (o)
      5'h00, 5'h02, 5'h04, 5'h05, 5'h07: oa = s[7:0];
      5'h01, 5'h03, 5'h06, 5'h08: orr = s[7:0];
      5'h09: oa = a & r;
      5'h0A: orr = a & r;
      5'h0B: oa = a & lit;
      5'h0E: oa = 8'h00;
      5'h0F: orr = 8'h00;
      5'h10: orr[b] = 1'b0;
      5'h11: oa = r - 8'h01;
      5'h12: orr = r - 8'h01;
      5'h13: oa = r + 8'h01;
      5'h14: orr = r + 8'h01;
      5'h15: oa = r;
      5'h16: orr = a;
      5'h17: oa = lit;
      default: oa = a;
    endcase
    if (o inside {5'h09, 5'h0B, 5'h0E, 5'h11, 5'h13, 5'h15}) of[2] = (oa == 8'h00);
    if (o inside {5'h0A, 5'h0F, 5'h12, 5'h14}) of[2] = (orr == 8'h00);
  endtask : model

  task automatic print_verdict();
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // Watchdog cuts a hang short.
  initial begin
    #200000;
    mismatches++;
    $display("mismatch watchdog expected finish seen timeout");
    print_verdict();
  end

  // Main sequence: reset values, bad addresses, then every opcode over every operand set.
  initial begin
    rst_n       = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    mismatches  = 0;
    check_count = 0;
    exp_ret     = 13'h0000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd("acc reset", ADDR_ACC, 32'h0);
    rd("status reset", ADDR_STATUS, 32'h0);
    rd("pc reset", ADDR_PC, 32'h0);
    rd("return reset", ADDR_RETURN, 32'h0);
    bus(1'b0, 8'h20, 32'h0, 1'b0, 1'b0);
    chk("unmapped read err", {31'h0, rerr}, 32'h1);
    bus(1'b1, 8'h05, 32'hFF, 1'b0, 1'b0);
    chk("unaligned write err", {31'h0, rerr}, 32'h1);
    rd("acc untouched", ADDR_ACC, 32'h0);
    for (int v = 0; v < 4; v++) begin
      for (int k = 0; k < 24; k++) begin
        op    = 5'(k);
        tgt   = {5'h0A, vl[v]};
        word  = {3'h0, op, 5'h00, vb[v], 3'h0, tgt};
        raddr = ADDR_REGS + {2'b00, vl[v][3:0], 2'b00};
        xfer  = (op == OP_CALL) || (op == OP_UNCONDITIONAL_JUMP);
        model(op, va[v], vr[v], vl[v], vb[v], vf[v], ea, er, ef);
        wr(ADDR_ACC, {24'h0, va[v]});
        wr(raddr, {24'h0, vr[v]});
        wr(ADDR_STATUS, {28'h0, vf[v]});
        wr(ADDR_PC, 32'h0000_0123);
        bus(1'b1, ADDR_INSTR, word, 1'b0, 1'b1);
        bus(1'b1, ADDR_RETURN, 32'h0, 1'b1, 1'b0);
        chk("wait states", 32'(rwaits), xfer ? 32'h1 : 32'h0); // one wait state for call and jump, none for the other opcodes
        chk("return write err", {31'h0, rerr}, 32'h0);
        if (op == OP_CALL) exp_ret = 13'h0124;
        rd("acc", ADDR_ACC, {24'h0, ea}); // accumulator
        rd("reg", raddr, {24'h0, er}); // register
        rd("status", ADDR_STATUS, {22'h0, xfer, 1'b0, 4'h0, ef}); // discard
        rd("pc", ADDR_PC, {19'h0, xfer ? tgt : 13'h0124}); // target
        rd("return", ADDR_RETURN, {19'h0, exp_ret}); // return point
      end
    end
    print_verdict();
  end

endmodule : tb_top
`default_nettype wire
